// File: pkg/io_cell_pkg.sv
// How it works
// - The fast capture latch is opened and closed by the output clock, not the input clock.
// - Input latch and input register take separate clocks; the register resamples the latch.
// - In latch-then-flop mode the early latch is open while its clock is low, then a rising flop.
// - In latch-then-latch mode the early latch is open low, then a latch open while its clock is high.
// - Each capture clock can be inverted inside the cell by a configuration bit.
// - With the fast capture latch in use the input delay defaults to the medium tap.
// - Output data may be inverted and either drive the pad directly or pass an output flop.
// - A high three-state control turns the output buffer off.
// - Output value polarity and three-state polarity are configured separately per cell.
// - Set/reset loads the output flop with its configured initial value; reset always clears it.
// - The output flop loads on a rising edge only with the clock enable high, else holds.
// - Outside open-drain use a three-state control that is high after tristate_invert floats the pad whatever the clock and data are.
// - Open-drain use drives the three-state control from the data with buffer data held low.
// - One clock enable serves input and output elements, steered per element, never inverted.
package io_cell_pkg;

  // ----------------------------------------
  // Input capture modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    CAP_DIRECT = 2'b00,
    CAP_FLOP = 2'b01,
    CAP_LATCH_FLOP = 2'b10,
    CAP_LATCH_LATCH = 2'b11
  } cap_mode_t;

  // ----------------------------------------
  // Input delay taps
  // ----------------------------------------
  typedef enum logic [1:0] {
    DLY_FULL = 2'b00,
    DLY_MEDIUM = 2'b01,
    DLY_NONE = 2'b10,
    DLY_AUTO = 2'b11
  } dly_sel_t;

  // Delay line length in clk stages per tap
  localparam int unsigned DLY_FULL_STAGES = 2;
  localparam int unsigned DLY_MED_STAGES = 1;
  localparam logic INIT_CLEARED = 1'b0;
  localparam logic INV_OFF = 1'b0;
  // Reset levels of the sampled clocks, the drain data and the driver enable
  localparam logic PREV_CLK_RST = 1'h0;
  localparam logic OD_DATA_LOW = 1'h0;
  localparam logic OE_N_FLOAT = 1'h1;

endpackage

// File: test/board_signal.sv
`timescale 1ns/1ps
// Board side of one pin: another driver or a pull-up when the cell lets go
module board_signal (
  input wire logic pad_out,
  input wire logic pad_oe_n,
  input wire logic ext_drive,
  input wire logic ext_val,
  output logic pad_in
);
  // A released pin takes the other driver's value, or the pull-up level when none drives; never the last driven value
  assign pad_in = !pad_oe_n ? pad_out : (ext_drive ? ext_val : 1'b1);
endmodule // board_signal

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import io_cell_pkg::*;
  logic clk, rst, clk_en, global_set_reset, in_clock, out_clock, cell_clock_enable;
  logic ce_to_input, ce_to_output, in_clock_invert, out_clock_invert, in_init_set;
  logic out_init_set, out_data, out_invert, out_registered, tristate_ctl, tristate_invert;
  logic open_drain, pad_in, pad_out, pad_oe_n, in_direct, in_captured, early_latch_q;
  logic ext_drive, ext_val, e_out, e_oe_n, m_reg, m_prev, v, eff, src;
  logic [31:0] r;
  logic [1:0] e_dly;
  logic e_fcl, e_in, e_dir, i_prev, ieff, oeff, dv, ice, lat;
  dly_sel_t dsel;
  cap_mode_t capture_mode;
  dly_sel_t delay_select;
  int fail_count = 0;
  int num_checks = 0;

  io_cell_capture_and_output dut (.clk, .rst, .clk_en, .global_set_reset, .in_clock,
    .out_clock, .cell_clock_enable, .ce_to_input, .ce_to_output, .in_clock_invert,
    .out_clock_invert, .capture_mode, .delay_select, .in_init_set, .out_init_set,
    .out_data, .out_invert, .out_registered, .tristate_ctl, .tristate_invert, .open_drain,
    .pad_in, .pad_out, .pad_oe_n, .in_direct, .in_captured, .early_latch_q);
  board_signal board (.pad_out, .pad_oe_n, .ext_drive, .ext_val, .pad_in);

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Reference cell: output flop, polarity, three-state and open drain
  always @(posedge clk) begin
    if (rst) begin
      e_out = 1'b0;
      e_oe_n = 1'b1;
      m_reg = 1'b0;
      m_prev = 1'b0;
    end else if (clk_en) begin
      v = out_data ^ out_invert;
      eff = out_clock ^ out_clock_invert;
      src = out_registered ? m_reg : v;
      e_out = open_drain ? 1'b0 : src;
      e_oe_n = open_drain ? src : (tristate_ctl ^ tristate_invert);
      if (global_set_reset) m_reg = out_init_set;
      else if (eff && !m_prev && (!ce_to_output || cell_clock_enable)) m_reg = v;
      m_prev = eff;
    end
  end

  // Reference input path: delay taps, early latch and input element
  always @(posedge clk) begin
    if (rst) begin
      e_dly = 2'h0;
      e_fcl = 1'b0;
      e_in = 1'b0;
      e_dir = 1'b0;
      i_prev = 1'b0;
    end else if (clk_en) begin
      ieff = in_clock ^ in_clock_invert;
      oeff = out_clock ^ out_clock_invert;
      lat = capture_mode == CAP_LATCH_FLOP || capture_mode == CAP_LATCH_LATCH;
      dsel = delay_select == DLY_AUTO ? (lat ? DLY_MEDIUM : DLY_FULL) : delay_select;
      dv = dsel == DLY_NONE ? pad_in : (dsel == DLY_MEDIUM ? e_dly[0] : e_dly[1]);
      ice = !ce_to_input || cell_clock_enable;
      if (global_set_reset) begin
        e_in = in_init_set;
        e_fcl = in_init_set;
      end else begin
        case (capture_mode)
          CAP_DIRECT: e_in = dv;
          CAP_FLOP: if (ieff && !i_prev && ice) e_in = dv;
          CAP_LATCH_FLOP: if (ieff && !i_prev && ice) e_in = e_fcl;
          default: if (ieff && ice) e_in = e_fcl;
        endcase
        if (!oeff) e_fcl = dv;
      end
      e_dly = {e_dly[0], pad_in};
      e_dir = pad_in;
      i_prev = ieff;
    end
  end

  // Phases cover both clock polarities with and without open drain
  initial begin
    {rst, clk_en, global_set_reset, in_clock, out_clock, cell_clock_enable, ce_to_input,
     ce_to_output, in_clock_invert, out_clock_invert, in_init_set, out_init_set, out_data,
     out_invert, out_registered, tristate_ctl, tristate_invert, open_drain, ext_drive,
     ext_val} = '0;
    rst = 1'b1;
    capture_mode = CAP_DIRECT;
    delay_select = DLY_AUTO;
    void'($urandom(32'h45178a34));
    for (int ph = 0; ph < 4; ph++) begin
      @(negedge clk);
      rst = 1'b1;
      clk_en = 1'b1;
      global_set_reset = 1'b0;
      out_clock_invert = ph[0];
      out_clock = ph[0];
      open_drain = ph[1];
      out_invert = 1'b0;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      repeat (400) begin
        check(pad_oe_n, e_oe_n);
        if (e_oe_n === 1'b0) check(pad_out, e_out);
        check(in_direct, e_dir);
        check(early_latch_q, e_fcl);
        check(in_captured, e_in);
        @(negedge clk);
        r = $urandom;
        clk_en = r[3:0] != 4'h0;
        global_set_reset = r[7:4] == 4'h0;
        // Output clock held still during set/reset so no output edge is in doubt
        if (!global_set_reset) out_clock = r[8];
        {out_data, out_registered, tristate_ctl, tristate_invert} = r[12:9];
        {cell_clock_enable, ce_to_output, in_clock, ce_to_input} = r[16:13];
        {in_init_set, out_init_set, ext_drive, ext_val, in_clock_invert} = r[21:17];
        out_invert = open_drain ? 1'b0 : r[22];
        capture_mode = cap_mode_t'(r[24:23]);
        delay_select = dly_sel_t'(r[26:25]);
      end
    end
    tally_and_finish();
  end

  // Hang guard
  initial begin
    #50us;
    fail_count++;
    tally_and_finish();
  end
endmodule // testbench

// File: verilog/io_cell_capture_and_output.sv
`timescale 1ns/1ps
// Sampled model of one I/O cell: the pin clocks arrive as ordinary
// synchronous inputs and edges are found by comparing with last value.
module io_cell_capture_and_output
  import io_cell_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic global_set_reset,
  input wire logic in_clock,
  input wire logic out_clock,
  input wire logic cell_clock_enable,
  input wire logic ce_to_input,
  input wire logic ce_to_output,
  input wire logic in_clock_invert,
  input wire logic out_clock_invert,
  input wire io_cell_pkg::cap_mode_t capture_mode,
  input wire io_cell_pkg::dly_sel_t delay_select,
  input wire logic in_init_set,
  input wire logic out_init_set,
  input wire logic out_data,
  input wire logic out_invert,
  input wire logic out_registered,
  input wire logic tristate_ctl,
  input wire logic tristate_invert,
  input wire logic open_drain,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe_n,
  output logic in_direct,
  output logic in_captured,
  output logic early_latch_q
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Pad sampling: delay taps, direct copy and last clock levels
  logic [DLY_FULL_STAGES-1:0] dly_q;
  logic [DLY_FULL_STAGES-1:0] dly_d;
  logic iclk_prev_q;
  logic iclk_prev_d;
  logic oclk_prev_q;
  logic oclk_prev_d;
  logic direct_q;
  logic direct_d;
  // Capture: early latch and the regular input element
  logic fcl_q;
  logic fcl_d;
  logic inreg_q;
  logic inreg_d;
  // Output: output flop, pad data and driver enable
  logic outreg_q;
  logic outreg_d;
  logic pad_out_q;
  logic pad_out_d;
  logic oe_n_q;
  logic oe_n_d;
  // Decoded controls shared by the groups
  logic iclk;
  logic oclk;
  logic iclk_rise;
  logic oclk_rise;
  logic delayed;
  logic use_fcl;
  logic in_ce;
  logic out_ce;
  logic drv_val;
  logic pad_src;
  logic ts_eff;
  dly_sel_t dly_eff;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Shared enable steered per element, never inverted
  function automatic logic steer_ce(input logic ce, input logic use_it);
    return use_it ? ce : 1'h1;
  endfunction

  // Rising edge of a clock level seen on two samples of clk
  function automatic logic clk_rose(input logic now_lvl, input logic prev_lvl);
    return now_lvl && !prev_lvl;
  endfunction

  // Modes that put the early latch in front of the input element
  function automatic logic latch_in_path(input cap_mode_t mode);
    return (mode == CAP_LATCH_FLOP) || (mode == CAP_LATCH_LATCH);
  endfunction

  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  // Clock polarity, enables and delay tap; no state is held here
  always_comb begin
    iclk = in_clock ^ in_clock_invert;
    oclk = out_clock ^ out_clock_invert;
    iclk_rise = clk_rose(iclk, iclk_prev_q);
    oclk_rise = clk_rose(oclk, oclk_prev_q);
    in_ce = steer_ce(cell_clock_enable, ce_to_input);
    out_ce = steer_ce(cell_clock_enable, ce_to_output);
    use_fcl = latch_in_path(capture_mode);
    // Auto picks medium behind the early latch for zero hold
    if (delay_select == DLY_AUTO) begin
      dly_eff = use_fcl ? DLY_MEDIUM : DLY_FULL;
    end else begin
      dly_eff = delay_select;
    end
    case (dly_eff)
      DLY_NONE: delayed = pad_in;
      DLY_MEDIUM: delayed = dly_q[DLY_MED_STAGES-1];
      DLY_FULL: delayed = dly_q[DLY_FULL_STAGES-1];
      default: delayed = dly_q[DLY_FULL_STAGES-1];
    endcase
  end

  // ----------------------------------------
  // Pad sampling
  // ----------------------------------------
  // Taps are whole clk stages, so hold margin is modelled, not timed
  always_comb begin
    dly_d = {dly_q[DLY_FULL_STAGES-1-DLY_MED_STAGES:0], pad_in};
    direct_d = pad_in;
    iclk_prev_d = iclk;
    oclk_prev_d = oclk;
  end

  // Sampling registers; clock history clears, so a clock already high after reset counts as a rise
  always_ff @(posedge clk) begin
    if (rst) begin
      dly_q <= '0;
      direct_q <= 1'h0;
      iclk_prev_q <= PREV_CLK_RST;
      oclk_prev_q <= PREV_CLK_RST;
    end else if (clk_en) begin
      dly_q <= dly_d;
      direct_q <= direct_d;
      iclk_prev_q <= iclk_prev_d;
      oclk_prev_q <= oclk_prev_d;
    end
  end

  // ----------------------------------------
  // Input capture
  // ----------------------------------------
  // Early latch on the output clock, input element on the input clock
  always_comb begin
    // Early latch open while output clock low
    fcl_d = (!oclk) ? delayed : fcl_q;
    case (capture_mode)
      CAP_FLOP: inreg_d = (iclk_rise && in_ce) ? delayed : inreg_q;
      CAP_LATCH_FLOP: inreg_d = (iclk_rise && in_ce) ? fcl_q : inreg_q;
      CAP_LATCH_LATCH: inreg_d = (iclk && in_ce) ? fcl_q : inreg_q;
      CAP_DIRECT: inreg_d = delayed;
      default: inreg_d = inreg_q;
    endcase
    // Set/reset beats any capture in this cycle
    if (global_set_reset) begin
      fcl_d = in_init_set;
      inreg_d = in_init_set;
    end
  end

  // Capture registers; reset clears, set/reset loads the init bits
  always_ff @(posedge clk) begin
    if (rst) begin
      fcl_q <= INIT_CLEARED;
      inreg_q <= INIT_CLEARED;
    end else if (clk_en) begin
      fcl_q <= fcl_d;
      inreg_q <= inreg_d;
    end
  end

  // ----------------------------------------
  // Output path
  // ----------------------------------------
  // Polarity, output flop and driver enable
  always_comb begin
    drv_val = out_data ^ out_invert;
    // Rising output clock with enable high loads, else hold
    outreg_d = (oclk_rise && out_ce) ? drv_val : outreg_q;
    if (global_set_reset) begin
      outreg_d = out_init_set;
    end
    pad_src = out_registered ? outreg_q : drv_val;
    ts_eff = tristate_ctl ^ tristate_invert;
    if (open_drain) begin
      // Data steers the enable; buffer input held low
      pad_out_d = OD_DATA_LOW;
      ts_eff = pad_src;
    end else begin
      pad_out_d = pad_src;
    end
    oe_n_d = ts_eff;
  end

  // Output registers; the driver stays off until configured
  always_ff @(posedge clk) begin
    if (rst) begin
      outreg_q <= INIT_CLEARED;
      pad_out_q <= OD_DATA_LOW;
      oe_n_q <= OE_N_FLOAT;
    end else if (clk_en) begin
      outreg_q <= outreg_d;
      pad_out_q <= pad_out_d;
      oe_n_q <= oe_n_d;
    end
  end

  // Every output comes straight from a register
  assign pad_out = pad_out_q;
  assign pad_oe_n = oe_n_q;
  assign in_direct = direct_q;
  assign in_captured = inreg_q;
  assign early_latch_q = fcl_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Steps of a transfer, named once and reused by the properties
  sequence oclk_rise_en;
    clk_en && oclk_rise && out_ce && !global_set_reset;
  endsequence

  sequence fcl_open;
    clk_en && !oclk && !global_set_reset;
  endsequence

  sequence flop_edge;
    clk_en && capture_mode == CAP_FLOP && iclk_rise && in_ce && !global_set_reset;
  endsequence

  sequence lf_edge;
    clk_en && capture_mode == CAP_LATCH_FLOP && iclk_rise && in_ce && !global_set_reset;
  endsequence

  sequence drive_step;
    clk_en && !open_drain;
  endsequence

  sequence drain_step;
    clk_en && open_drain;
  endsequence

  AST_DIRECT_PASS: assert property (@(posedge clk) disable iff (rst)
    clk_en |=> in_direct == $past(pad_in))
    else $error("direct input copy lost");
  AST_FCL_OPEN: assert property (@(posedge clk) disable iff (rst)
    fcl_open |=> early_latch_q == $past(delayed))
    else $error("early latch not transparent");
  AST_FLOP_LOAD: assert property (@(posedge clk) disable iff (rst)
    flop_edge |=> in_captured == $past(delayed))
    else $error("input flop missed its edge");
  AST_LF_LOAD: assert property (@(posedge clk) disable iff (rst)
    lf_edge |=> in_captured == $past(fcl_q))
    else $error("input flop missed early latch");
  AST_PAD_DRIVE: assert property (@(posedge clk) disable iff (rst)
    drive_step |=> pad_out == $past(pad_src))
    else $error("pad data wrong path");
  AST_OD_ENABLE: assert property (@(posedge clk) disable iff (rst)
    drain_step |=> pad_oe_n == $past(pad_src))
    else $error("open drain enable not from data");
  AST_TS_POL: assert property (@(posedge clk) disable iff (rst)
    drive_step |=> pad_oe_n == $past(tristate_ctl ^ tristate_invert))
    else $error("three-state polarity wrong");
  AST_FREEZE: assert property (@(posedge clk) disable iff (rst)
    !clk_en |=> $stable(outreg_q) && $stable(inreg_q) && $stable(fcl_q))
    else $error("state moved with clock enable low");

  AST_OUT_LOAD: assert property (@(posedge clk) disable iff (rst)
    oclk_rise_en |=> outreg_q == $past(drv_val))
    else $error("output flop missed its load");
  AST_OUT_HOLD: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !out_ce && !global_set_reset) |=> $stable(outreg_q))
    else $error("output flop changed with enable low");
  AST_GSR_OUT: assert property (@(posedge clk) disable iff (rst)
    (clk_en && global_set_reset) |=> outreg_q == $past(out_init_set))
    else $error("output flop ignored set/reset");
  AST_GSR_IN: assert property (@(posedge clk) disable iff (rst)
    (clk_en && global_set_reset) |=> inreg_q == $past(in_init_set) && fcl_q == $past(in_init_set))
    else $error("input elements ignored set/reset");
  AST_TRISTATE: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !open_drain && (tristate_ctl ^ tristate_invert)) |=> pad_oe_n)
    else $error("pad driven while three-stated");
  AST_FCL_HOLD: assert property (@(posedge clk) disable iff (rst)
    (clk_en && oclk && !global_set_reset) |=> $stable(fcl_q))
    else $error("early latch moved while closed");
  AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (rst)
    (clk_en && open_drain) |=> !pad_out)
    else $error("open drain drove high");
  AST_LL_PASS: assert property (@(posedge clk) disable iff (rst)
    (clk_en && capture_mode == CAP_LATCH_LATCH && iclk && in_ce && !global_set_reset)
      |=> inreg_q == $past(fcl_q))
    else $error("second latch not transparent");
  AST_LF_HOLD: assert property (@(posedge clk) disable iff (rst)
    (clk_en && capture_mode == CAP_LATCH_FLOP && !(iclk && !iclk_prev_q) && !global_set_reset)
      |=> $stable(inreg_q))
    else $error("input flop moved without edge");

endmodule // io_cell_capture_and_output
